//--- smls_pkg.sv
// Package of constants and types for the servo mode and limit selector.
package smls_pkg;

  // Parameter register offsets.
  localparam logic [15:0] SMLS_ADDR_MONITOR_SELECT = 16'h0006;
  localparam logic [15:0] SMLS_ADDR_TORQUE_FULL_SCALE = 16'h0152;
  localparam logic [15:0] SMLS_ADDR_MAX_SPEED = 16'h0200;
  localparam logic [15:0] SMLS_ADDR_LIMIT_ENABLE = 16'h0202;
  localparam logic [15:0] SMLS_ADDR_CONTROL_MODE = 16'h0204;
  localparam logic [15:0] SMLS_ADDR_SPEED_PARAM_BASE = 16'h0210;
  localparam logic [15:0] SMLS_ADDR_TORQUE_PARAM_BASE = 16'h0220;

  // Reset values and ranges.
  localparam logic [15:0] SMLS_FULL_SCALE_RESET = 16'h0064;
  localparam logic [15:0] SMLS_FULL_SCALE_MAX = 16'h03E8;
  localparam logic [15:0] SMLS_MONITOR_RESET = 16'h0001;
  localparam logic [15:0] SMLS_MONITOR_DIGIT_MAX = 16'h0007;
  localparam logic [15:0] SMLS_MAX_SPEED_RESET = 16'h1388;
  localparam logic [15:0] SMLS_LIMIT_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] SMLS_PARAM_RESET = 16'h0000;

  // Limit enable field positions.
  localparam int SMLS_SPEED_LIMIT_BIT = 0;
  localparam int SMLS_TORQUE_LIMIT_BIT = 1;

  // Monitor digit fields.
  localparam int SMLS_MONITOR_CHANNEL_ONE_LSB = 4;
  localparam int SMLS_MONITOR_CHANNEL_TWO_LSB = 0;

  // Control mode codes.
  localparam logic [7:0] SMLS_MODE_PULSE_POSITION = 8'h00;
  localparam logic [7:0] SMLS_MODE_INTERNAL_POSITION = 8'h01;
  localparam logic [7:0] SMLS_MODE_SPEED = 8'h02;
  localparam logic [7:0] SMLS_MODE_TORQUE = 8'h03;
  localparam logic [7:0] SMLS_MODE_ZERO_SPEED = 8'h04;
  localparam logic [7:0] SMLS_MODE_ZERO_TORQUE = 8'h05;
  localparam logic [7:0] SMLS_MODE_POSITION_SPEED_DUAL = 8'h06;
  localparam logic [7:0] SMLS_MODE_POSITION_TORQUE_DUAL = 8'h07;
  localparam logic [7:0] SMLS_MODE_SPEED_TORQUE_DUAL = 8'h0A;

  // Analog scaling: input in millivolts, 10 V full scale, result in whole percent.
  localparam logic [31:0] SMLS_VOLT_DIVISOR = 32'h0000_2710;
  localparam logic [31:0] SMLS_PCT_MULT = 32'h0000_0064;

  // Debounce time and derived cycle count at the 200 MHz clock.
  localparam int SMLS_CLK_MHZ = 200;
  localparam int SMLS_DEBOUNCE_NS = 1000;
  localparam int SMLS_DEBOUNCE_CYCLES = (SMLS_DEBOUNCE_NS * SMLS_CLK_MHZ) / 1000;
  localparam int SMLS_DEBOUNCE_W = 8;

  // Digital-input count.
  localparam int SMLS_DI_COUNT = 7;

  // Monitor source digits.
  localparam logic [3:0] SMLS_MON_MOTOR_SPEED = 4'h0;
  localparam logic [3:0] SMLS_MON_MOTOR_TORQUE = 4'h1;
  localparam logic [3:0] SMLS_MON_PULSE_FREQ = 4'h2;
  localparam logic [3:0] SMLS_MON_SPEED_CMD = 4'h3;
  localparam logic [3:0] SMLS_MON_TORQUE_CMD = 4'h4;
  localparam logic [3:0] SMLS_MON_BUS_VOLTAGE = 4'h5;

  typedef enum logic [2:0] {
    SMLS_LOOP_PULSE_POSITION,
    SMLS_LOOP_INTERNAL_POSITION,
    SMLS_LOOP_SPEED,
    SMLS_LOOP_ZERO_SPEED,
    SMLS_LOOP_TORQUE,
    SMLS_LOOP_ZERO_TORQUE
  } smls_loop_t;

endpackage

//--- smls_debounce.sv
// Two-flop synchroniser and debounce filter for one digital input.
`timescale 1ns/10ps
module smls_debounce (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Raw and filtered level.
  input  wire logic din,
  output logic      dout
);
  import smls_pkg::*;

  logic                       sync_a;
  logic                       sync_b;
  logic [SMLS_DEBOUNCE_W-1:0] stable_cnt;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= din;
      sync_b <= sync_a;
    end
  end

  // The output follows only after the input has held for the debounce time.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stable_cnt <= '0;
      dout       <= 1'b0;
    end else if (sync_b == dout) begin
      stable_cnt <= '0;
    end else if (stable_cnt == SMLS_DEBOUNCE_W'(SMLS_DEBOUNCE_CYCLES - 1)) begin
      stable_cnt <= '0;
      dout       <= sync_b;
    end else begin
      stable_cnt <= stable_cnt + 1'b1;
    end
  end

endmodule

//--- smls_mode_select.sv
// Servo control-mode, command-source and limit selection with analog scaling.
//
// Contract
// - Torque mode: torque command percent = volts times full scale over ten.
// - Position and speed modes: torque limit percent from same analog scaling.
// - Torque full scale is 0 to 1000 percent, default 100.
// - Zero-reference torque forces zero; analog torque mode uses analog input.
// - Code 06: pulse position or speed, chosen by speed-position input.
// - Code 07: pulse position or torque, chosen by torque-position input.
// - Code 0A: speed or torque, chosen by speed-torque input.
// - No dual mode joins zero-speed and zero-torque modes.
// - Position/speed dual: pulse position, speed from analog or internal.
// - Speed/torque dual: switch on gives torque, off gives speed.
// - Speed selectors choose analog or one of three speed parameters.
// - Torque selectors choose analog or one of three torque parameters.
// - Position/torque dual: pulse position, torque from analog or internal.
// - Motor speed always clamped to maximum-speed parameter.
// - Speed limit only in torque mode, when its enable bit is one.
// - Speed limit from selected speed parameter or analog input.
// - Torque limit only in pulse position or speed loop, when enabled.
// - Torque limit from selected torque parameter or analog input.
// - Two monitor channels chosen by select parameter 00 to 77.
// - Input functions reassigned only in torque mode (selector pins swapped) and dual modes (switch pins).
// - Monitor digit picks speed, torque, pulse, commands or bus voltage.
// - High digit drives channel one, low digit channel two.
`timescale 1ns/10ps
module smls_mode_select (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Parameter write and read port.
  input  wire logic        param_wr,
  input  wire logic [15:0] param_addr,
  input  wire logic [15:0] param_wdata,
  output logic      [15:0] param_rdata,
  // Digital inputs in pin order (reassigned by mode).
  input  wire logic [6:0]  di_pins,
  // Analog references in millivolts, signed.
  input  wire logic [15:0] analog_torque_mv,
  input  wire logic [15:0] analog_speed_mv,
  // Drive quantities for monitoring.
  input  wire logic [15:0] motor_speed,
  input  wire logic [15:0] motor_torque,
  input  wire logic [15:0] pulse_freq,
  input  wire logic [15:0] bus_voltage,
  // Selected loop and commands.
  output smls_pkg::smls_loop_t active_loop,
  output logic      [15:0] speed_command,
  output logic      [15:0] torque_command,
  output logic      [15:0] speed_limit,
  output logic             speed_limit_active,
  output logic      [15:0] torque_limit,
  output logic             torque_limit_active,
  output logic             pulse_position_source,
  // Monitor channels.
  output logic      [15:0] monitor_channel_one,
  output logic      [15:0] monitor_channel_two
);
  import smls_pkg::*;

  logic [15:0]    monitor_select_param;
  logic [15:0]    torque_full_scale_param;
  logic [15:0]    max_speed_param;
  logic [15:0]    limit_enable_param;
  logic [7:0]     control_mode;
  logic [15:0]    speed_param [3];
  logic [15:0]    torque_param [3];
  logic [6:0]     di_clean;
  logic           speed_select_bit0;
  logic           speed_select_bit1;
  logic           torque_select_bit0;
  logic           torque_select_bit1;
  logic           speed_position_switch;
  logic           torque_position_switch;
  logic           speed_torque_switch;
  logic           analog_torque_input;
  smls_loop_t     next_loop;
  logic [15:0]    analog_pct;
  logic [31:0]    scaled;
  logic [15:0]    next_speed_sel;
  logic [15:0]    next_torque_sel;
  logic [15:0]    next_speed_cmd;
  logic [15:0]    next_torque_cmd;
  logic [15:0]    clamp_speed;

  // Each digital input is cleaned before it can change the mode.
  genvar gi;
  generate
    for (gi = 0; gi < SMLS_DI_COUNT; gi++) begin : g_di
      smls_debounce u_deb (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (di_pins[gi]),
        .dout    (di_clean[gi])
      );
    end
  endgenerate

  // Pin functions follow the selected mode; single modes reuse pins for selectors.
  always_comb begin
    speed_select_bit0      = di_clean[0];
    speed_select_bit1      = di_clean[1];
    torque_select_bit0     = di_clean[2];
    torque_select_bit1     = di_clean[3];
    speed_position_switch  = 1'b0;
    torque_position_switch = 1'b0;
    speed_torque_switch    = 1'b0;
    if (control_mode == SMLS_MODE_POSITION_SPEED_DUAL) begin
      speed_position_switch = di_clean[4];
    end else if (control_mode == SMLS_MODE_POSITION_TORQUE_DUAL) begin
      torque_position_switch = di_clean[5];
    end else if (control_mode == SMLS_MODE_SPEED_TORQUE_DUAL) begin
      speed_torque_switch = di_clean[6];
    end else if (control_mode == SMLS_MODE_TORQUE) begin
      torque_select_bit0 = di_clean[0];
      torque_select_bit1 = di_clean[1];
      speed_select_bit0  = di_clean[2];
      speed_select_bit1  = di_clean[3];
    end
  end

  // Parameter writes; out-of-range full scale and monitor digits are ignored.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      monitor_select_param    <= SMLS_MONITOR_RESET;
      torque_full_scale_param <= SMLS_FULL_SCALE_RESET;
      max_speed_param         <= SMLS_MAX_SPEED_RESET;
      limit_enable_param      <= SMLS_LIMIT_ENABLE_RESET;
      control_mode            <= SMLS_MODE_PULSE_POSITION;
      for (int i = 0; i < 3; i++) begin
        speed_param[i]  <= SMLS_PARAM_RESET;
        torque_param[i] <= SMLS_PARAM_RESET;
      end
    end else if (param_wr) begin
      if (param_addr == SMLS_ADDR_MONITOR_SELECT) begin
        if (param_wdata[3:0] <= SMLS_MONITOR_DIGIT_MAX[3:0] && param_wdata[7:4] <=
            SMLS_MONITOR_DIGIT_MAX[3:0] && param_wdata[15:8] == 8'h00) begin
          monitor_select_param <= param_wdata;
        end
      end else if (param_addr == SMLS_ADDR_TORQUE_FULL_SCALE) begin
        if (param_wdata <= SMLS_FULL_SCALE_MAX) begin
          torque_full_scale_param <= param_wdata;
        end
      end else if (param_addr == SMLS_ADDR_MAX_SPEED) begin
        max_speed_param <= param_wdata;
      end else if (param_addr == SMLS_ADDR_LIMIT_ENABLE) begin
        limit_enable_param <= param_wdata;
      end else if (param_addr == SMLS_ADDR_CONTROL_MODE) begin
        // Codes for unsupported dual combinations are refused.
        if (param_wdata[7:0] <= SMLS_MODE_POSITION_TORQUE_DUAL ||
            param_wdata[7:0] == SMLS_MODE_SPEED_TORQUE_DUAL) begin
          control_mode <= param_wdata[7:0];
        end
      end else begin
        for (int i = 0; i < 3; i++) begin
          if (param_addr == SMLS_ADDR_SPEED_PARAM_BASE + 16'(2 * i)) begin
            speed_param[i] <= param_wdata;
          end
          if (param_addr == SMLS_ADDR_TORQUE_PARAM_BASE + 16'(2 * i)) begin
            torque_param[i] <= param_wdata;
          end
        end
      end
    end
  end

  // Read data come from a register one cycle after the address.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      param_rdata <= '0;
    end else if (param_addr == SMLS_ADDR_MONITOR_SELECT) begin
      param_rdata <= monitor_select_param;
    end else if (param_addr == SMLS_ADDR_TORQUE_FULL_SCALE) begin
      param_rdata <= torque_full_scale_param;
    end else if (param_addr == SMLS_ADDR_MAX_SPEED) begin
      param_rdata <= max_speed_param;
    end else if (param_addr == SMLS_ADDR_LIMIT_ENABLE) begin
      param_rdata <= limit_enable_param;
    end else if (param_addr == SMLS_ADDR_CONTROL_MODE) begin
      param_rdata <= {8'h00, control_mode};
    end else begin
      param_rdata <= '0;
    end
  end

  // Loop choice from the mode code and the dual-mode switch inputs.
  always_comb begin
    next_loop = SMLS_LOOP_PULSE_POSITION;
    case (control_mode)
      SMLS_MODE_INTERNAL_POSITION: next_loop = SMLS_LOOP_INTERNAL_POSITION;
      SMLS_MODE_SPEED:             next_loop = SMLS_LOOP_SPEED;
      SMLS_MODE_TORQUE:            next_loop = SMLS_LOOP_TORQUE;
      SMLS_MODE_ZERO_SPEED:        next_loop = SMLS_LOOP_ZERO_SPEED;
      SMLS_MODE_ZERO_TORQUE:       next_loop = SMLS_LOOP_ZERO_TORQUE;
      SMLS_MODE_POSITION_SPEED_DUAL: begin
        next_loop = speed_position_switch ? SMLS_LOOP_SPEED
                                          : SMLS_LOOP_PULSE_POSITION;
      end
      SMLS_MODE_POSITION_TORQUE_DUAL: begin
        next_loop = torque_position_switch ? SMLS_LOOP_TORQUE
                                           : SMLS_LOOP_PULSE_POSITION;
      end
      SMLS_MODE_SPEED_TORQUE_DUAL: begin
        next_loop = speed_torque_switch ? SMLS_LOOP_TORQUE
                                        : SMLS_LOOP_SPEED;
      end
      default:                     next_loop = SMLS_LOOP_PULSE_POSITION;
    endcase
  end

  // Analog torque percent; negative input reads as zero, overflow saturates.
  always_comb begin
    scaled = 32'(analog_torque_mv[14:0]) * 32'(torque_full_scale_param);
    scaled = scaled / SMLS_VOLT_DIVISOR;
    if (analog_torque_mv[15]) begin
      analog_pct = '0;
    end else if (scaled > 32'(SMLS_FULL_SCALE_MAX)) begin
      analog_pct = SMLS_FULL_SCALE_MAX;
    end else begin
      analog_pct = scaled[15:0];
    end
  end

  // Source selectors: code zero takes the analog input.
  always_comb begin
    analog_torque_input = {torque_select_bit1, torque_select_bit0} == 2'b00;
    case ({speed_select_bit1, speed_select_bit0})
      2'b00:   next_speed_sel = analog_speed_mv;
      2'b01:   next_speed_sel = speed_param[0];
      2'b10:   next_speed_sel = speed_param[1];
      default: next_speed_sel = speed_param[2];
    endcase
    case ({torque_select_bit1, torque_select_bit0})
      2'b00:   next_torque_sel = analog_pct;
      2'b01:   next_torque_sel = torque_param[0];
      2'b10:   next_torque_sel = torque_param[1];
      default: next_torque_sel = torque_param[2];
    endcase
  end

  // Speed command is clamped to the maximum speed whatever the mode.
  always_comb begin
    clamp_speed = (next_speed_sel > max_speed_param) ? max_speed_param
                                                     : next_speed_sel;
    next_speed_cmd = '0;
    next_torque_cmd = '0;
    if (next_loop == SMLS_LOOP_SPEED) begin
      next_speed_cmd = clamp_speed;
    end else if (next_loop == SMLS_LOOP_TORQUE) begin
      next_torque_cmd = analog_torque_input ? analog_pct : next_torque_sel;
    end else if (next_loop == SMLS_LOOP_ZERO_TORQUE) begin
      next_torque_cmd = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      active_loop           <= SMLS_LOOP_PULSE_POSITION;
      speed_command         <= '0;
      torque_command        <= '0;
      pulse_position_source <= 1'b0;
    end else begin
      active_loop           <= next_loop;
      speed_command         <= next_speed_cmd;
      torque_command        <= next_torque_cmd;
      pulse_position_source <= next_loop == SMLS_LOOP_PULSE_POSITION;
    end
  end

  // Limits apply only in the loops and with the enable bits that allow them.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      speed_limit         <= '0;
      speed_limit_active  <= 1'b0;
      torque_limit        <= '0;
      torque_limit_active <= 1'b0;
    end else begin
      speed_limit_active  <= next_loop == SMLS_LOOP_TORQUE &&
                             limit_enable_param[SMLS_SPEED_LIMIT_BIT];
      speed_limit         <= clamp_speed;
      torque_limit_active <= (next_loop == SMLS_LOOP_PULSE_POSITION ||
                              next_loop == SMLS_LOOP_SPEED) &&
                             limit_enable_param[SMLS_TORQUE_LIMIT_BIT];
      torque_limit        <= next_torque_sel;
    end
  end

  // Monitor routing, one digit per channel.
  function automatic logic [15:0] smls_mon_pick(input logic [3:0] digit);
    case (digit)
      SMLS_MON_MOTOR_SPEED:  smls_mon_pick = motor_speed;
      SMLS_MON_MOTOR_TORQUE: smls_mon_pick = motor_torque;
      SMLS_MON_PULSE_FREQ:   smls_mon_pick = pulse_freq;
      SMLS_MON_SPEED_CMD:    smls_mon_pick = speed_command;
      SMLS_MON_TORQUE_CMD:   smls_mon_pick = torque_command;
      SMLS_MON_BUS_VOLTAGE:  smls_mon_pick = bus_voltage;
      default:               smls_mon_pick = '0;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      monitor_channel_one <= '0;
      monitor_channel_two <= '0;
    end else begin
      monitor_channel_one <= smls_mon_pick(monitor_select_param[SMLS_MONITOR_CHANNEL_ONE_LSB +: 4]);
      monitor_channel_two <= smls_mon_pick(monitor_select_param[SMLS_MONITOR_CHANNEL_TWO_LSB +: 4]);
    end
  end

endmodule

//--- smls_mode_select_chk.sv
// Port-level assertions for the servo mode and limit selector.
`timescale 1ns/10ps
module smls_mode_select_chk (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Parameter port.
  input wire logic        param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  input wire logic [15:0] param_rdata,
  // Selection results.
  input wire logic [6:0]  di_pins,
  input smls_pkg::smls_loop_t active_loop,
  input wire logic [15:0] torque_command,
  input wire logic        speed_limit_active,
  input wire logic        torque_limit_active
);
  import smls_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_reset_clears: assert property (disable iff (1'b0) !rstn |=>
    active_loop == SMLS_LOOP_PULSE_POSITION && torque_command == 16'h0000 && !torque_limit_active)
    else $error("outputs not cleared by reset");
  a_zero_torque: assert property (active_loop == SMLS_LOOP_ZERO_TORQUE &&
    $past(active_loop) == SMLS_LOOP_ZERO_TORQUE |-> torque_command == 16'h0000)
    else $error("torque command not zero in zero-reference torque loop");
  a_spd_lim_mode: assert property (speed_limit_active && $stable(active_loop) |->
    active_loop inside {SMLS_LOOP_TORQUE, SMLS_LOOP_ZERO_TORQUE})
    else $error("speed limit active outside torque loop");
  a_trq_lim_mode: assert property (torque_limit_active && $stable(active_loop) |->
    active_loop inside {SMLS_LOOP_PULSE_POSITION, SMLS_LOOP_INTERNAL_POSITION, SMLS_LOOP_SPEED})
    else $error("torque limit active outside position or speed loop");
  a_fs_readback: assert property (param_wr && param_addr == SMLS_ADDR_TORQUE_FULL_SCALE &&
    param_wdata <= SMLS_FULL_SCALE_MAX ##1 !param_wr && $stable(param_addr)
    |=> param_rdata == $past(param_wdata, 2))
    else $error("full scale write not read back");
  a_fs_refused: assert property (param_wr && param_addr == SMLS_ADDR_TORQUE_FULL_SCALE &&
    param_wdata > SMLS_FULL_SCALE_MAX ##1 !param_wr && $stable(param_addr)
    |=> $stable(param_rdata))
    else $error("out of range full scale accepted");
  a_mon_refused: assert property (param_wr && param_addr == SMLS_ADDR_MONITOR_SELECT &&
    (param_wdata[15:8] != 8'h00 || param_wdata[7:4] > 4'h7 || param_wdata[3:0] > 4'h7)
    ##1 !param_wr && $stable(param_addr) |=> $stable(param_rdata))
    else $error("out of range monitor select accepted");
  a_unmapped_zero: assert property (param_addr == 16'h0100 |=> param_rdata == 16'h0000)
    else $error("unmapped address reads nonzero");
  a_di_filtered: assert property ((!param_wr)[*3] ##0 $changed(di_pins) |=>
    $stable(active_loop)[*8])
    else $error("loop changed without input filtering");
endmodule

bind smls_mode_select smls_mode_select_chk chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .param_wr(param_wr), .param_addr(param_addr),
  .param_wdata(param_wdata), .param_rdata(param_rdata), .di_pins(di_pins),
  .active_loop(active_loop), .torque_command(torque_command),
  .speed_limit_active(speed_limit_active), .torque_limit_active(torque_limit_active)
);

//--- smls_host.sv
// Behavioural host controller driving the digital inputs and analog references.
`timescale 1ns/10ps
module smls_host (
  // Clock.
  input  wire logic        clk_sys,
  // Levels requested by the test sequence.
  input  wire logic [6:0]  set_di,
  input  wire logic [15:0] set_tq,
  input  wire logic [15:0] set_sp,
  // Pins toward the drive.
  output logic      [6:0]  di_pins = 7'h00,
  output logic      [15:0] analog_torque_mv = 16'h0000,
  output logic      [15:0] analog_speed_mv = 16'h0000
);
  // Levels move only on an edge and then hold, like a real controller's output stage.
  always @(posedge clk_sys) begin
    di_pins <= set_di;
  end
  always @(posedge clk_sys) begin
    analog_torque_mv <= set_tq;
    analog_speed_mv  <= set_sp;
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the servo mode and limit selector.
`timescale 1ns/10ps
module tb_top;
  import smls_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        param_wr = 1'b0;
  logic [15:0] param_addr = 16'h0000;
  logic [15:0] param_wdata = 16'h0000;
  logic [15:0] param_rdata;
  logic [6:0]  set_di = 7'h00;
  logic [15:0] set_tq = 16'h0000;
  logic [15:0] set_sp = 16'h0000;
  logic [6:0]  di_pins;
  logic [15:0] an_tq, an_sp, spd_cmd, trq_cmd, spd_lim, trq_lim, mon_one, mon_two;
  logic        spd_lim_on, trq_lim_on, pulse_src, ok;
  smls_loop_t  loop, l0;
  int          err_count = 0;
  int          n_checks = 0;
  logic [15:0] spd_exp [4] = '{16'h04D2, 16'h006F, 16'h00DE, 16'h1388};
  logic [7:0]  dual_code [3] = '{8'h06, 8'h07, 8'h0A};
  smls_loop_t  dual_a [3] = '{SMLS_LOOP_PULSE_POSITION, SMLS_LOOP_PULSE_POSITION, SMLS_LOOP_SPEED};
  smls_loop_t  dual_b [3] = '{SMLS_LOOP_SPEED, SMLS_LOOP_TORQUE, SMLS_LOOP_TORQUE};
  logic [3:0]  mon_dig [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
  logic [15:0] mon_exp [6] = '{16'h1111, 16'h2222, 16'h3333, 16'h0032, 16'h5555, 16'h0000};

  always #2.5 clk_sys = ~clk_sys;

  smls_host host_u (.clk_sys(clk_sys), .set_di(set_di), .set_tq(set_tq), .set_sp(set_sp),
    .di_pins(di_pins), .analog_torque_mv(an_tq), .analog_speed_mv(an_sp));

  smls_mode_select dut_u (.clk_sys(clk_sys), .rstn(rstn), .param_wr(param_wr),
    .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .di_pins(di_pins), .analog_torque_mv(an_tq), .analog_speed_mv(an_sp),
    .motor_speed(16'h1111), .motor_torque(16'h2222), .pulse_freq(16'h3333),
    .bus_voltage(16'h5555), .active_loop(loop), .speed_command(spd_cmd),
    .torque_command(trq_cmd), .speed_limit(spd_lim), .speed_limit_active(spd_lim_on),
    .torque_limit(trq_lim), .torque_limit_active(trq_lim_on),
    .pulse_position_source(pulse_src), .monitor_channel_one(mon_one),
    .monitor_channel_two(mon_two));

  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    param_wr    <= 1'b1;
    param_addr  <= a;
    param_wdata <= d;
    @(posedge clk_sys);
    param_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
    @(posedge clk_sys);
    param_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
    chk16(name, exp, param_rdata);
  endtask

  // The input filter needs about 203 cycles, so each change is given 263 before looking.
  task automatic di_set(input logic [6:0] v, input logic [15:0] tq, input logic [15:0] sp);
    @(posedge clk_sys);
    set_di <= v;
    set_tq <= tq;
    set_sp <= sp;
    repeat (263) @(posedge clk_sys);
    #1;
  endtask

  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    stop_test;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h0064, "fs_reset");
    rd(SMLS_ADDR_MONITOR_SELECT, 16'h0001, "mon_reset");
    rd(16'h0100, 16'h0000, "unmapped");
    chk16("mon_one_rst", 16'h1111, mon_one);
    chk16("mon_two_rst", 16'h2222, mon_two);
    chk16("pulse_src", 16'h0001, {15'h0, pulse_src});
    wr(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h01F4);
    rd(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h01F4, "fs_500");
    wr(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h03E9);
    rd(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h01F4, "fs_refuse");
    wr(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h03E8);
    rd(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h03E8, "fs_max");
    // Torque loop: 12 V at 1000 percent would be 1200 percent, so it must saturate.
    wr(SMLS_ADDR_CONTROL_MODE, 16'h0003);
    di_set(7'h00, 16'h2EE0, 16'h04D2);
    chk16("loop_t", 16'(SMLS_LOOP_TORQUE), 16'(loop));
    chk16("tq_sat", 16'h03E8, trq_cmd);
    wr(SMLS_ADDR_TORQUE_FULL_SCALE, 16'h0064);
    di_set(7'h00, 16'h1388, 16'h04D2);
    chk16("tq_cmd", 16'h0032, trq_cmd);
    wr(SMLS_ADDR_SPEED_PARAM_BASE, 16'h006F);
    wr(SMLS_ADDR_SPEED_PARAM_BASE + 16'h0002, 16'h00DE);
    wr(SMLS_ADDR_SPEED_PARAM_BASE + 16'h0004, 16'h1770);
    wr(SMLS_ADDR_TORQUE_PARAM_BASE + 16'h0002, 16'h012C);
    wr(SMLS_ADDR_LIMIT_ENABLE, 16'h0001);
    di_set(7'b0000110, 16'h1388, 16'h04D2);
    chk16("tq_int", 16'h012C, trq_cmd);
    chk16("spd_lim_on", 16'h0001, {15'h0, spd_lim_on});
    chk16("spd_lim", 16'h006F, spd_lim);
    chk16("tq_lim_off", 16'h0000, {15'h0, trq_lim_on});
    // Speed loop: walk all four selector codes; the last one exceeds the maximum speed.
    wr(SMLS_ADDR_CONTROL_MODE, 16'h0002);
    wr(SMLS_ADDR_LIMIT_ENABLE, 16'h0002);
    for (int s = 0; s < 4; s++) begin
      di_set({5'h00, s[1:0]}, 16'h1388, 16'h04D2);
      chk16("spd_cmd", spd_exp[s], spd_cmd);
    end
    chk16("loop_s", 16'(SMLS_LOOP_SPEED), 16'(loop));
    chk16("tq_lim_on", 16'h0001, {15'h0, trq_lim_on});
    chk16("tq_lim", 16'h0032, trq_lim);
    chk16("spd_lim_off", 16'h0000, {15'h0, spd_lim_on});
    wr(SMLS_ADDR_CONTROL_MODE, 16'h0005);
    rd(SMLS_ADDR_CONTROL_MODE, 16'h0005, "mode_tz");
    chk16("loop_tz", 16'(SMLS_LOOP_ZERO_TORQUE), 16'(loop));
    chk16("tz_cmd", 16'h0000, trq_cmd);
    chk16("pulse_off", 16'h0000, {15'h0, pulse_src});
    wr(SMLS_ADDR_CONTROL_MODE, 16'h0008);
    rd(SMLS_ADDR_CONTROL_MODE, 16'h0005, "mode_refuse");
    for (int m = 0; m < 3; m++) begin
      wr(SMLS_ADDR_CONTROL_MODE, {8'h00, dual_code[m]});
      di_set(7'h00, 16'h1388, 16'h04D2);
      l0 = loop;
      di_set(7'(1 << (m + 4)), 16'h1388, 16'h04D2);
      ok = (l0 === dual_a[m] && loop === dual_b[m]) ||
           (m < 2 && l0 === dual_b[m] && loop === dual_a[m]);
      chk16("dual_loop", 16'h0001, {15'h0, ok});
    end
    for (int d = 0; d < 6; d++) begin
      wr(SMLS_ADDR_MONITOR_SELECT, {8'h00, mon_dig[d], 4'h5});
      rd(SMLS_ADDR_MONITOR_SELECT, {8'h00, mon_dig[d], 4'h5}, "mon_sel");
      chk16("mon_one", mon_exp[d], mon_one);
      chk16("mon_two", 16'h5555, mon_two);
    end
    wr(SMLS_ADDR_MONITOR_SELECT, 16'h0078);
    rd(SMLS_ADDR_MONITOR_SELECT, 16'h0065, "mon_refuse");
    // Switch off drops the speed/torque dual mode to speed, so the speed command shows.
    di_set(7'h00, 16'h1388, 16'h04D2);
    wr(SMLS_ADDR_MONITOR_SELECT, 16'h0035);
    rd(SMLS_ADDR_MONITOR_SELECT, 16'h0035, "mon_sel");
    chk16("mon_spd", 16'h04D2, mon_one);
    stop_test;
  end
endmodule
